/* File: verilog/bbx_exec.sv */
// Execution unit for bit branches, decrement branches and CPU control
`include "bbx_regs.svh"

// Summary of operation
// - Bit-set branch: PC+length+displacement when bit one
// - Bit-set branch takes 8, 9, 10, 11 cycles
// - Bit-clear branch when bit zero; 3/4 bytes
// - Bit-clear branch takes 8, 10 or 11 cycles
// - Test-clear: branch and clear bit when set
// - Status-word form may change zero, carry flags
// - Test-clear takes 8, 10 or 12 cycles
// - B/C decrement, branch if nonzero, 6 cycles
// - Memory byte decrement, 8 or 10 cycles
// - Interrupt-on sets master enable, 6 cycles
// - Interrupt-off clears master enable, 6 cycles
// - Cycles counted at selected CPU clock rate
// - Longer count outside high-speed RAM
module bbx_exec
  import bbx_pkg::*;
#(
  parameter int SEL_W = 3
) (
  // System
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Clock control selection
  input  wire logic [SEL_W-1:0] cpu_clk_sel,
  // Instruction issue
  input  wire logic             start,
  input  wire bbx_instr_t       instr,
  output logic                  busy,
  output logic                  done,
  // Results
  output logic [15:0]           pc,
  output logic [7:0]            program_status_word,
  output bbx_wb_t               wb,
  // Low-power modes
  input  wire logic             wake,
  output logic                  halt_mode,
  output logic                  stop_mode
);

  typedef struct packed {
    bbx_phase_t phase;
    logic [3:0] cnt;
    logic [3:0] cycles;
    logic [2:0] len;
    bbx_instr_t ins;
    logic [15:0] pc;
    logic [7:0] stat;
    bbx_wb_t    wb;
    logic       done;
    logic       busy;
    logic       halt;
    logic       stop;
  } bbx_state_t;

  bbx_state_t st_q;
  bbx_state_t st_d;
  logic       cpu_en;
  logic [2:0] t_len;
  logic [3:0] t_cycles;

  ////////////////////////////////////////////////////////////////////////
  bbx_cpu_clk_div #(
    .SEL_W   (SEL_W)
  ) u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .div_sel (cpu_clk_sel),
    .cpu_en  (cpu_en)
  );

  bbx_timing u_timing (
    .op       (instr.op),
    .form     (instr.form),
    .in_hsram (instr.in_hsram),
    .len      (t_len),
    .cycles   (t_cycles)
  );

  ////////////////////////////////////////////////////////////////////////
  // Target is the byte after the instruction plus the signed offset
  function automatic logic [15:0] branch_target(logic [15:0] base,
                                                logic [2:0]  len,
                                                logic [7:0]  disp);
    logic [15:0] sext;
    sext = {{8{disp[7]}}, disp};
    return 16'(base + {13'h0000, len} + sext);
  endfunction

  function automatic logic [15:0] next_pc(logic [15:0] base,
                                          logic [2:0]  len);
    return 16'(base + {13'h0000, len});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] src;
  logic       tbit;
  logic [7:0] dec;
  logic       take;
  logic [7:0] cleared;

  always_comb begin
    src     = (st_q.ins.form == BBX_FORM_STATUS) ? st_q.stat : st_q.ins.opnd;
    tbit    = src[st_q.ins.bit_idx];
    dec     = 8'(st_q.ins.opnd - 8'h01);
    cleared = src & ~(8'h01 << st_q.ins.bit_idx);
    case (st_q.ins.op)
      BBX_OP_BIT_SET: take = tbit;
      BBX_OP_BIT_CLR: take = !tbit;
      BBX_OP_TST_CLR: take = tbit;
      BBX_OP_DEC_B, BBX_OP_DEC_C, BBX_OP_DEC_SADDR:
        take = (dec != 8'h00);
      default:        take = 1'b0;
    endcase
  end

  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    st_d.wb   = '0;
    case (st_q.phase)
      BBX_PH_IDLE: begin
        if (start) begin
          st_d.phase  = BBX_PH_EXEC;
          st_d.ins    = instr;
          st_d.len    = t_len;
          st_d.cycles = t_cycles;
          st_d.cnt    = 4'h0;
        end
      end
      BBX_PH_EXEC: begin
        // Counts whole CPU clock cycles only
        if (cpu_en) begin
          st_d.cnt = 4'(st_q.cnt + 4'h1);
          if (st_d.cnt == st_q.cycles) begin
            st_d.phase = BBX_PH_IDLE;
            st_d.done  = 1'b1;
            st_d.pc    = take ?
                         branch_target(st_q.ins.pc, st_q.len, st_q.ins.disp) :
                         next_pc(st_q.ins.pc, st_q.len);
            st_d.wb.op   = st_q.ins.op;
            st_d.wb.form = st_q.ins.form;
            case (st_q.ins.op)
              BBX_OP_TST_CLR: begin
                if (tbit) begin
                  // Status word is kept here; other forms go out for store
                  if (st_q.ins.form == BBX_FORM_STATUS) begin
                    st_d.stat = cleared;
                  end else begin
                    st_d.wb.valid = 1'b1;
                    st_d.wb.data  = cleared;
                  end
                end
              end
              BBX_OP_DEC_B, BBX_OP_DEC_C, BBX_OP_DEC_SADDR: begin
                st_d.wb.valid = 1'b1;
                st_d.wb.data  = dec;
              end
              BBX_OP_IRQ_ON:  st_d.stat[`BBX_SW_IRQ_EN] = 1'b1;
              BBX_OP_IRQ_OFF: st_d.stat[`BBX_SW_IRQ_EN] = 1'b0;
              BBX_OP_BANK_SEL: begin
                st_d.stat[`BBX_SW_BANK_HI] = st_q.ins.bank[1];
                st_d.stat[`BBX_SW_BANK_LO] = st_q.ins.bank[0];
              end
              BBX_OP_HALT: st_d.phase = BBX_PH_HALT;
              BBX_OP_STOP: st_d.phase = BBX_PH_STOP;
              default: ;
            endcase
          end
        end
      end
      BBX_PH_HALT, BBX_PH_STOP: begin
        // A wake request ends either low-power mode and returns to idle
        if (wake) begin
          st_d.phase = BBX_PH_IDLE;
        end
      end
      default: st_d.phase = BBX_PH_IDLE;
    endcase
    // Mode outputs are registered copies of the next phase
    st_d.busy = (st_d.phase != BBX_PH_IDLE);
    st_d.halt = (st_d.phase == BBX_PH_HALT);
    st_d.stop = (st_d.phase == BBX_PH_STOP);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.phase <= BBX_PH_IDLE;
      st_q.pc    <= `BBX_PC_RESET;
      st_q.stat  <= `BBX_SW_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy                = st_q.busy;
  assign done                = st_q.done;
  assign pc                  = st_q.pc;
  assign program_status_word = st_q.stat;
  assign wb                  = st_q.wb;
  assign halt_mode           = st_q.halt;
  assign stop_mode           = st_q.stop;

  ////////////////////////////////////////////////////////////////////////
  // Helper: CPU cycles seen since the instruction was taken
  logic [4:0] seen_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (st_q.phase == BBX_PH_IDLE)) begin
      seen_q <= 5'h00;
    end else if (st_q.phase == BBX_PH_EXEC && cpu_en) begin
      seen_q <= 5'(seen_q + 5'h01);
    end
  end

  sequence s_issue;
    st_q.phase == BBX_PH_IDLE && start;
  endsequence

  sequence s_finish;
    st_q.phase == BBX_PH_EXEC && cpu_en && (st_q.cnt + 4'h1 == st_q.cycles);
  endsequence

  a_done_count: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    done |-> ({1'b0, st_q.cycles} == seen_q))
    else $error("instruction ended on wrong cycle count");

  a_bitset_cyc: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_issue and (instr.op == BBX_OP_BIT_SET && instr.form == BBX_FORM_ACC))
    |=> st_q.cycles == 4'h8)
    else $error("bit-set accumulator form not 8 cycles");

  a_tclr_slow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_issue and (instr.op == BBX_OP_TST_CLR
                  && instr.form == BBX_FORM_STATUS))
    |=> st_q.cycles == 4'hC && st_q.len == 3'h4)
    else $error("test-clear status word form timing wrong");

  a_bitclr_len: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_issue and (instr.op == BBX_OP_BIT_CLR && instr.form == BBX_FORM_SADDR))
    |=> st_q.len == 3'h4
        && st_q.cycles == (st_q.ins.in_hsram ? 4'hA : 4'hB))
    else $error("bit-clear direct form length or timing wrong");

  a_branch_tgt: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_BIT_SET && tbit))
    |=> pc == 16'($past(st_q.ins.pc) + {13'h0000, $past(st_q.len)}
                  + {{8{$past(st_q.ins.disp[7])}}, $past(st_q.ins.disp)}))
    else $error("bit-set branch target wrong");

  a_tclr_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_TST_CLR && !tbit))
    |=> !wb.valid
        && pc == 16'($past(st_q.ins.pc) + {13'h0000, $past(st_q.len)}))
    else $error("test-clear with bit zero changed state");

  a_tclr_status: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_TST_CLR
                   && st_q.ins.form == BBX_FORM_STATUS && tbit))
    |=> !wb.valid && !program_status_word[$past(st_q.ins.bit_idx)])
    else $error("status word bit not cleared in place");

  a_dec_store: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_DEC_B))
    |=> wb.valid && wb.data == 8'($past(st_q.ins.opnd) - 8'h01) && done)
    else $error("register decrement not written back");

  a_dec_mem_cyc: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_issue and (instr.op == BBX_OP_DEC_SADDR))
    |=> st_q.len == 3'h3
        && st_q.cycles == (st_q.ins.in_hsram ? 4'h8 : 4'hA))
    else $error("memory decrement length or timing wrong");

  a_busy_issue: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_issue |=> busy && !done)
    else $error("issued instruction not busy");

  a_irq_on: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_IRQ_ON))
    |=> program_status_word[`BBX_SW_IRQ_EN] && done)
    else $error("interrupt enable not set");

  a_irq_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_IRQ_OFF))
    |=> !program_status_word[`BBX_SW_IRQ_EN])
    else $error("interrupt enable not cleared");

  a_bank_write: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_BANK_SEL))
    |=> program_status_word[`BBX_SW_BANK_HI] == $past(st_q.ins.bank[1])
        && program_status_word[`BBX_SW_BANK_LO] == $past(st_q.ins.bank[0]))
    else $error("bank select bits not written");

  a_halt_enter: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_HALT)) |=> halt_mode && !stop_mode)
    else $error("halt mode not entered");

  a_stop_enter: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_finish and (st_q.ins.op == BBX_OP_STOP)) |=> stop_mode && !halt_mode)
    else $error("stop mode not entered");

endmodule

/* File: inc/bbx_regs.svh */
// Constants of the bit-branch and CPU control execution unit
`ifndef BBX_REGS_SVH
`define BBX_REGS_SVH

// Program status word bit positions and reset value
`define BBX_SW_IRQ_EN     7
`define BBX_SW_ZERO       6
`define BBX_SW_BANK_HI    5
`define BBX_SW_AUX_CARRY  4
`define BBX_SW_BANK_LO    3
`define BBX_SW_CARRY      0
`define BBX_SW_RESET      8'h02
`define BBX_PC_RESET      16'h0000

// Instruction lengths in bytes
`define BBX_LEN_1         3'h1
`define BBX_LEN_2         3'h2
`define BBX_LEN_3         3'h3
`define BBX_LEN_4         3'h4

// Instruction cycle counts in CPU clock cycles
`define BBX_CYC_2         4'h2
`define BBX_CYC_4         4'h4
`define BBX_CYC_6         4'h6
`define BBX_CYC_8         4'h8
`define BBX_CYC_9         4'h9
`define BBX_CYC_10        4'hA
`define BBX_CYC_11        4'hB
`define BBX_CYC_12        4'hC

// Widest CPU clock divider selection
`define BBX_DIV_SEL_MAX   3'h4

`endif

/* File: inc/bbx_pkg.sv */
// Types of the bit-branch and CPU control execution unit
package bbx_pkg;

  typedef enum logic [3:0] {
    BBX_OP_NOP,
    BBX_OP_BIT_SET,
    BBX_OP_BIT_CLR,
    BBX_OP_TST_CLR,
    BBX_OP_DEC_B,
    BBX_OP_DEC_C,
    BBX_OP_DEC_SADDR,
    BBX_OP_IRQ_ON,
    BBX_OP_IRQ_OFF,
    BBX_OP_BANK_SEL,
    BBX_OP_HALT,
    BBX_OP_STOP
  } bbx_op_t;

  typedef enum logic [2:0] {
    BBX_FORM_SADDR,
    BBX_FORM_SFR,
    BBX_FORM_ACC,
    BBX_FORM_STATUS,
    BBX_FORM_PTR
  } bbx_form_t;

  typedef enum logic [1:0] {
    BBX_PH_IDLE,
    BBX_PH_EXEC,
    BBX_PH_HALT,
    BBX_PH_STOP
  } bbx_phase_t;

  // Decoded instruction from the fetch path with its operand byte
  typedef struct packed {
    bbx_op_t    op;
    bbx_form_t  form;
    logic       in_hsram;
    logic [2:0] bit_idx;
    logic [7:0] disp;
    logic [1:0] bank;
    logic [7:0] opnd;
    logic [15:0] pc;
  } bbx_instr_t;

  // Operand write-back towards the register file or memory
  typedef struct packed {
    logic       valid;
    bbx_op_t    op;
    bbx_form_t  form;
    logic [7:0] data;
  } bbx_wb_t;

endpackage

/* File: verilog/bbx_cpu_clk_div.sv */
// CPU clock enable divider steered by the clock control selection
`include "bbx_regs.svh"

module bbx_cpu_clk_div
  import bbx_pkg::*;
#(
  parameter int SEL_W = 3
) (
  // System
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Selection and enable
  input  wire logic [SEL_W-1:0] div_sel,
  output logic                  cpu_en
);

  logic [7:0] cnt_q;
  logic [7:0] mask;

  // Enable every 2**div_sel system cycles; selections above the max clamp
  always_comb begin
    if (div_sel > `BBX_DIV_SEL_MAX) begin
      mask = 8'h0F;
    end else begin
      mask = 8'(({8'h01} << div_sel) - 8'h01);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if ((cnt_q & mask) == mask) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign cpu_en = ((cnt_q & mask) == mask);

endmodule

/* File: verilog/bbx_timing.sv */
// Length and cycle count table for each instruction and operand form
`include "bbx_regs.svh"

module bbx_timing
  import bbx_pkg::*;
(
  // Instruction
  input  wire bbx_op_t    op,
  input  wire bbx_form_t  form,
  input  wire logic       in_hsram,
  // Timing
  output logic [2:0]      len,
  output logic [3:0]      cycles
);

  logic fast;

  // Special function and status word operands never count as fast RAM
  assign fast = in_hsram && (form != BBX_FORM_SFR) &&
                (form != BBX_FORM_STATUS);

  always_comb begin
    len    = `BBX_LEN_1;
    cycles = `BBX_CYC_2;
    case (op)
      BBX_OP_BIT_SET: begin
        len = (form == BBX_FORM_SFR) ? `BBX_LEN_4 : `BBX_LEN_3;
        case (form)
          BBX_FORM_ACC:   cycles = `BBX_CYC_8;
          BBX_FORM_SADDR: cycles = fast ? `BBX_CYC_8 : `BBX_CYC_9;
          BBX_FORM_STATUS: cycles = `BBX_CYC_9;
          BBX_FORM_PTR:   cycles = fast ? `BBX_CYC_10 : `BBX_CYC_11;
          default:        cycles = `BBX_CYC_11;
        endcase
      end
      BBX_OP_BIT_CLR, BBX_OP_TST_CLR: begin
        len = (form == BBX_FORM_ACC || form == BBX_FORM_PTR) ?
              `BBX_LEN_3 : `BBX_LEN_4;
        if (form == BBX_FORM_ACC) begin
          cycles = `BBX_CYC_8;
        end else if (fast) begin
          cycles = `BBX_CYC_10;
        end else if (op == BBX_OP_BIT_CLR) begin
          cycles = `BBX_CYC_11;
        end else begin
          cycles = `BBX_CYC_12;
        end
      end
      BBX_OP_DEC_B, BBX_OP_DEC_C: begin
        len    = `BBX_LEN_2;
        cycles = `BBX_CYC_6;
      end
      BBX_OP_DEC_SADDR: begin
        len    = `BBX_LEN_3;
        cycles = in_hsram ? `BBX_CYC_8 : `BBX_CYC_10;
      end
      BBX_OP_IRQ_ON, BBX_OP_IRQ_OFF, BBX_OP_HALT, BBX_OP_STOP: begin
        len    = `BBX_LEN_2;
        cycles = `BBX_CYC_6;
      end
      BBX_OP_BANK_SEL: begin
        len    = `BBX_LEN_2;
        cycles = `BBX_CYC_4;
      end
      default: begin
        len    = `BBX_LEN_1;
        cycles = `BBX_CYC_2;
      end
    endcase
  end

endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the bit-branch and CPU control execution unit
module tb_top
  import bbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // System
  logic        clk_sys;
  logic        rst_n;
  // Stimulus
  logic [2:0]  cpu_clk_sel;
  logic        start;
  bbx_instr_t  instr;
  logic        wake;
  // Observed
  logic        busy;
  logic        done;
  logic [15:0] pc;
  logic [7:0]  program_status_word;
  bbx_wb_t     wb;
  logic        halt_mode;
  logic        stop_mode;
  // Bench state
  int          bad_count;
  int          compares;
  int          cycles_q = 0;
  logic [7:0]  exp_stat;
  logic [7:0]  disp_q;
  logic [2:0]  bidx_q;
  logic [1:0]  bank_q;

  ////////////////////////////////////////////////////////////////////////////
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  bbx_exec #(
    .SEL_W (3)
  ) dut (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .cpu_clk_sel         (cpu_clk_sel),
    .start               (start),
    .instr               (instr),
    .busy                (busy),
    .done                (done),
    .pc                  (pc),
    .program_status_word (program_status_word),
    .wb                  (wb),
    .wake                (wake),
    .halt_mode           (halt_mode),
    .stop_mode           (stop_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Issue one instruction and check timing, target and write-back
  task automatic go(input bbx_op_t op, input bbx_form_t f, input logic hs,
                    input logic [7:0] opnd, input logic [3:0] cyc,
                    input logic [2:0] len);
    int          n;
    int          m;
    logic        tk;
    logic [15:0] ipc;
    logic [15:0] exp_pc;
    ipc = 16'h10F8;
    tk = opnd[bidx_q];
    if (op == BBX_OP_BIT_CLR) begin
      tk = ~tk;
    end else if (op inside {BBX_OP_DEC_B, BBX_OP_DEC_C, BBX_OP_DEC_SADDR}) begin
      tk = (opnd != 8'h01);
    end else if (!(op inside {BBX_OP_BIT_SET, BBX_OP_TST_CLR})) begin
      tk = 1'b0;
    end
    exp_pc = ipc + 16'(len) + (tk ? {{8{disp_q[7]}}, disp_q} : 16'h0000);
    @(posedge clk_sys);
    instr <= '{op: op, form: f, in_hsram: hs, bit_idx: bidx_q,
               disp: disp_q, bank: bank_q, opnd: opnd, pc: ipc};
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    n = 0;
    #1;
    chk("busy", 16'(busy), 16'h0001);
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    m = 1 << cpu_clk_sel;
    if (m == 1) begin
      chk("cycles", 16'(n), 16'(cyc));
    end else begin
      chk("scaled cycles", 16'(n >= (cyc - 1) * m + 1 && n <= (cyc + 1) * m),
          16'h0001);
    end
    chk("pc", pc, exp_pc);
    chk("status", 16'(program_status_word), 16'(exp_stat));
    if (op inside {BBX_OP_DEC_B, BBX_OP_DEC_C, BBX_OP_DEC_SADDR}) begin
      chk("dec valid", 16'(wb.valid), 16'h0001);
      chk("dec data", 16'(wb.data), 16'(8'(opnd - 8'h01)));
    end else if (op == BBX_OP_TST_CLR && f != BBX_FORM_STATUS && tk) begin
      chk("clr valid", 16'(wb.valid), 16'h0001);
      chk("clr data", 16'(wb.data), 16'(opnd & ~(8'h01 << bidx_q)));
    end else begin
      chk("no store", 16'(wb.valid), 16'h0000);
    end
  endtask

  // Low-power entry, then wake back to idle
  task automatic lowp(input bbx_op_t op);
    go(op, BBX_FORM_SADDR, 1'h1, 8'h00, 4'h6, 3'h2);
    chk("halt", 16'(halt_mode), 16'(op == BBX_OP_HALT));
    chk("stop", 16'(stop_mode), 16'(op == BBX_OP_STOP));
    chk("busy low power", 16'(busy), 16'h0001);
    @(posedge clk_sys);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    #1;
    chk("woken", 16'({halt_mode, stop_mode, busy}), 16'h0000);
  endtask

  // Hang guard: whole run needs well under two thousand cycles
  always @(posedge clk_sys) begin
    cycles_q <= cycles_q + 1;
    if (cycles_q == 5000) begin
      bad_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    wake = 1'b0;
    cpu_clk_sel = 3'h0;
    instr = '0;
    bad_count = 0;
    compares = 0;
    exp_stat = 8'h02;
    disp_q = 8'hF0;
    bidx_q = 3'h2;
    bank_q = 2'h2;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("reset status", 16'(program_status_word), 16'h0002);
    chk("reset pc", pc, 16'h0000);
    chk("reset flags", 16'({busy, done, halt_mode, stop_mode}), 16'h0000);
    go(BBX_OP_BIT_SET, BBX_FORM_SADDR, 1'h1, 8'h04, 4'h8, 3'h3);
    go(BBX_OP_BIT_SET, BBX_FORM_SADDR, 1'h0, 8'hFB, 4'h9, 3'h3);
    go(BBX_OP_BIT_SET, BBX_FORM_SFR, 1'h0, 8'h04, 4'hB, 3'h4);
    go(BBX_OP_BIT_SET, BBX_FORM_ACC, 1'h1, 8'hFB, 4'h8, 3'h3);
    go(BBX_OP_BIT_SET, BBX_FORM_PTR, 1'h1, 8'h04, 4'hA, 3'h3);
    go(BBX_OP_BIT_SET, BBX_FORM_PTR, 1'h0, 8'h04, 4'hB, 3'h3);
    disp_q = 8'h7F;
    go(BBX_OP_BIT_CLR, BBX_FORM_SADDR, 1'h1, 8'hFB, 4'hA, 3'h4);
    go(BBX_OP_BIT_CLR, BBX_FORM_SADDR, 1'h0, 8'h04, 4'hB, 3'h4);
    go(BBX_OP_BIT_CLR, BBX_FORM_SFR, 1'h1, 8'hFB, 4'hB, 3'h4);
    go(BBX_OP_BIT_CLR, BBX_FORM_ACC, 1'h1, 8'hFB, 4'h8, 3'h3);
    go(BBX_OP_BIT_CLR, BBX_FORM_PTR, 1'h1, 8'h04, 4'hA, 3'h3);
    go(BBX_OP_BIT_CLR, BBX_FORM_PTR, 1'h0, 8'hFB, 4'hB, 3'h3);
    disp_q = 8'h80;
    go(BBX_OP_TST_CLR, BBX_FORM_SADDR, 1'h1, 8'h04, 4'hA, 3'h4);
    go(BBX_OP_TST_CLR, BBX_FORM_SADDR, 1'h0, 8'hFB, 4'hC, 3'h4);
    go(BBX_OP_TST_CLR, BBX_FORM_SFR, 1'h1, 8'h04, 4'hC, 3'h4);
    go(BBX_OP_TST_CLR, BBX_FORM_ACC, 1'h1, 8'h04, 4'h8, 3'h3);
    go(BBX_OP_TST_CLR, BBX_FORM_PTR, 1'h1, 8'h04, 4'hA, 3'h3);
    go(BBX_OP_TST_CLR, BBX_FORM_PTR, 1'h0, 8'h04, 4'hC, 3'h3);
    go(BBX_OP_DEC_B, BBX_FORM_SADDR, 1'h1, 8'h01, 4'h6, 3'h2);
    go(BBX_OP_DEC_C, BBX_FORM_SADDR, 1'h1, 8'h00, 4'h6, 3'h2);
    go(BBX_OP_DEC_SADDR, BBX_FORM_SADDR, 1'h1, 8'h05, 4'h8, 3'h3);
    go(BBX_OP_DEC_SADDR, BBX_FORM_SADDR, 1'h0, 8'h01, 4'hA, 3'h3);
    exp_stat = 8'h82;
    go(BBX_OP_IRQ_ON, BBX_FORM_SADDR, 1'h1, 8'h00, 4'h6, 3'h2);
    // Status-word forms test the master enable bit
    bidx_q = 3'h7;
    go(BBX_OP_BIT_SET, BBX_FORM_STATUS, 1'h1, 8'h82, 4'h9, 3'h3);
    go(BBX_OP_BIT_CLR, BBX_FORM_STATUS, 1'h1, 8'h82, 4'hB, 3'h4);
    exp_stat = 8'h02;
    go(BBX_OP_TST_CLR, BBX_FORM_STATUS, 1'h1, 8'h82, 4'hC, 3'h4);
    bidx_q = 3'h2;
    exp_stat = 8'h82;
    go(BBX_OP_IRQ_ON, BBX_FORM_SADDR, 1'h1, 8'h00, 4'h6, 3'h2);
    exp_stat = 8'h02;
    go(BBX_OP_IRQ_OFF, BBX_FORM_SADDR, 1'h1, 8'h00, 4'h6, 3'h2);
    exp_stat = 8'h22;
    go(BBX_OP_BANK_SEL, BBX_FORM_SADDR, 1'h1, 8'h00, 4'h4, 3'h2);
    go(BBX_OP_NOP, BBX_FORM_SADDR, 1'h1, 8'h00, 4'h2, 3'h1);
    lowp(BBX_OP_HALT);
    lowp(BBX_OP_STOP);
    @(posedge clk_sys);
    cpu_clk_sel <= 3'h1;
    go(BBX_OP_BIT_SET, BBX_FORM_ACC, 1'h1, 8'h04, 4'h8, 3'h3);
    @(posedge clk_sys);
    cpu_clk_sel <= 3'h2;
    go(BBX_OP_DEC_B, BBX_FORM_SADDR, 1'h1, 8'h03, 4'h6, 3'h2);
    results();
  end

endmodule
